// ===== hw/bps_regs.svh
`ifndef BPS_REGS_SVH
`define BPS_REGS_SVH

// Register byte offsets
`define BPS_OFS_CTRL    8'h00
`define BPS_OFS_STAT    8'h04
`define BPS_OFS_MASK    8'h08

// Control register fields
`define BPS_CTRL_PRI_EN 0
`define BPS_CTRL_SEC_EN 1
`define BPS_CTRL_RST    2'h0

// Status and mask register fields
`define BPS_ST_PRI_DET  0
`define BPS_ST_SEC_DET  1
`define BPS_ST_PRI_DPD  2
`define BPS_ST_SEC_DPD  3
`define BPS_MASK_RST    4'h0
`define BPS_STAT_RST    4'h0

// Bus answers and padding
`define BPS_RESP_OKAY   2'h0
`define BPS_RESP_SLVERR 2'h2
`define BPS_PAD_CTRL    30'h0000_0000
`define BPS_PAD_STAT    28'h000_0000
`define BPS_WORD_RST    32'h0000_0000
`define BPS_ADDR_RST    8'h00
`define BPS_STRB_RST    4'h0

`endif

// ===== hw/bps_pkg.sv
package bps_pkg;
   typedef enum logic [1:0] {BPS_READ, BPS_POSTED_WR, BPS_DELAYED_WR}
      bps_xact_e;
   typedef enum logic {BPS_DOWN, BPS_UP} bps_dir_e;
   typedef enum logic {BPS_BUS_PRI, BPS_BUS_SEC} bps_bus_e;
endpackage

// ===== hw/bps_sync2.sv
`timescale 1ns/10ps
module bps_sync2 #(
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Pin in, synchronised level out
   input  wire logic d,
   output logic      q
);
   logic meta_reg;
   logic meta_next;
   logic q_next;

   always_comb
   begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end
      else
      begin
         meta_reg <= meta_next;
         q        <= q_next;
      end
   end
endmodule

// ===== hw/bps_sticky.sv
`timescale 1ns/10ps
module bps_sticky (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Hardware set, software clear
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);
   logic q_next;

   // Set wins so an error in the clearing cycle is kept
   always_comb
   begin
      q_next = (q & ~clr) | set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         q <= 1'b0;
      else
         q <= q_next;
   end
endmodule

// ===== hw/bps_parity_status.sv
`timescale 1ns/10ps
`include "bps_regs.svh"

// Operation
// - A data parity error found on the primary bus sets primary detected.
// - Primary detected sets only for up reads or down writes seen on primary.
// - A data parity error found on the secondary bus sets secondary detected.
// - Secondary detected sets only for down reads or up writes on secondary.
// - Primary parity detected is set only while the bridge masters primary.
// - Primary parity detected is set only while the primary enable is one.
// - Primary parity detected fires on the primary error pin or an own error.
// - Primary parity detected sets for up errors on primary with enable one.
// - Secondary parity detected needs the bridge to master the secondary bus.
// - Secondary parity detected needs the secondary enable at one.
// - Secondary parity detected fires on the secondary pin or an own error.
// - Secondary parity detected sets for down errors on secondary, enabled.
module bps_parity_status (
   // Clock and reset
   input  wire logic               aclk,
   input  wire logic               aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]         awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   // AXI4-Lite write response
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // AXI4-Lite read
   input  wire logic [7:0]         araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Transaction error report from the bridge's own parity checkers
   input  wire logic               evt_valid,
   input  wire bps_pkg::bps_xact_e evt_type,
   input  wire bps_pkg::bps_dir_e  evt_dir,
   input  wire bps_pkg::bps_bus_e  evt_bus,
   // Bridge currently acts as master on each bus
   input  wire logic               pri_master_active,
   input  wire logic               sec_master_active,
   // Parity error pins, active low, asynchronous
   input  wire logic               primary_parity_error_pin_n,
   input  wire logic               secondary_parity_error_pin_n,
   // Interrupt
   output logic                    irq
);
   import bps_pkg::*;

   logic [1:0]  ctrl_reg, ctrl_next;
   logic [3:0]  mask_reg, mask_next;
   logic        irq_next;
   logic [3:0]  stat;
   logic [3:0]  stat_set;
   logic [3:0]  stat_clr;
   logic        pri_pin_n_sync;
   logic        sec_pin_n_sync;
   logic        ev_pri, ev_sec;
   logic        aw_got_reg, aw_got_next;
   logic        w_got_reg, w_got_next;
   logic [7:0]  waddr_reg, waddr_next;
   logic [31:0] wdat_reg, wdat_next;
   logic [3:0]  wstb_reg, wstb_next;
   logic        awready_next, wready_next, bvalid_next;
   logic [1:0]  bresp_next;
   logic        arready_next, rvalid_next;
   logic [31:0] rdata_next;
   logic [1:0]  rresp_next;
   logic        wr_fire;
   logic        wr_mapped;
   logic        rd_mapped;
   logic [31:0] rd_word;

   // Pins cross two flops before any logic looks at them
   bps_sync2 #(.RST_VAL(1'b1)) u_pri_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (primary_parity_error_pin_n),
      .q       (pri_pin_n_sync)
   );
   bps_sync2 #(.RST_VAL(1'b1)) u_sec_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (secondary_parity_error_pin_n),
      .q       (sec_pin_n_sync)
   );

   // Classification of each report
   always_comb
   begin
      ev_pri = evt_valid && (evt_bus == BPS_BUS_PRI);
      ev_sec = evt_valid && (evt_bus == BPS_BUS_SEC);
      stat_set[`BPS_ST_PRI_DET] = ev_pri &&
         (((evt_dir == BPS_UP) && (evt_type == BPS_READ)) ||
          ((evt_dir == BPS_DOWN) && (evt_type != BPS_READ)));
      stat_set[`BPS_ST_SEC_DET] = ev_sec &&
         (((evt_dir == BPS_DOWN) && (evt_type == BPS_READ)) ||
          ((evt_dir == BPS_UP) && (evt_type != BPS_READ)));
      // Upstream means the bridge masters the primary bus
      stat_set[`BPS_ST_PRI_DPD] = ctrl_reg[`BPS_CTRL_PRI_EN] &&
         ((ev_pri && (evt_dir == BPS_UP)) ||
          (!pri_pin_n_sync && pri_master_active));
      stat_set[`BPS_ST_SEC_DPD] = ctrl_reg[`BPS_CTRL_SEC_EN] &&
         ((ev_sec && (evt_dir == BPS_DOWN)) ||
          (!sec_pin_n_sync && sec_master_active));
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_stat
         bps_sticky u_bit (
            .aclk    (aclk),
            .aresetn (aresetn),
            .set     (stat_set[gi]),
            .clr     (stat_clr[gi]),
            .q       (stat[gi])
         );
      end
   endgenerate

   // Write channel: address and data are taken in either order
   always_comb
   begin
      wr_fire   = aw_got_reg && w_got_reg && !bvalid;
      wr_mapped = (waddr_reg == `BPS_OFS_CTRL) ||
                  (waddr_reg == `BPS_OFS_STAT) ||
                  (waddr_reg == `BPS_OFS_MASK);
      aw_got_next = aw_got_reg;
      w_got_next  = w_got_reg;
      waddr_next  = waddr_reg;
      wdat_next   = wdat_reg;
      wstb_next   = wstb_reg;
      bvalid_next = bvalid;
      bresp_next  = bresp;
      if (awvalid && awready)
      begin
         aw_got_next = 1'b1;
         waddr_next  = awaddr;
      end
      if (wvalid && wready)
      begin
         w_got_next = 1'b1;
         wdat_next  = wdata;
         wstb_next  = wstrb;
      end
      if (wr_fire)
      begin
         aw_got_next = 1'b0;
         w_got_next  = 1'b0;
         bvalid_next = 1'b1;
         bresp_next  = wr_mapped ? `BPS_RESP_OKAY : `BPS_RESP_SLVERR;
      end
      if (bvalid && bready)
         bvalid_next = 1'b0;
      awready_next = !aw_got_next && !bvalid_next;
      wready_next  = !w_got_next && !bvalid_next;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         waddr_reg  <= `BPS_ADDR_RST;
         wdat_reg   <= `BPS_WORD_RST;
         wstb_reg   <= `BPS_STRB_RST;
         awready    <= 1'b0;
         wready     <= 1'b0;
         bvalid     <= 1'b0;
         bresp      <= `BPS_RESP_OKAY;
      end
      else
      begin
         aw_got_reg <= aw_got_next;
         w_got_reg  <= w_got_next;
         waddr_reg  <= waddr_next;
         wdat_reg   <= wdat_next;
         wstb_reg   <= wstb_next;
         awready    <= awready_next;
         wready     <= wready_next;
         bvalid     <= bvalid_next;
         bresp      <= bresp_next;
      end
   end

   // Register effects of a write; only byte lane 0 holds live bits
   always_comb
   begin
      ctrl_next = ctrl_reg;
      mask_next = mask_reg;
      stat_clr  = `BPS_STAT_RST;
      if (wr_fire && wstb_reg[0])
      begin
         if (waddr_reg == `BPS_OFS_CTRL)
            ctrl_next = wdat_reg[1:0];
         if (waddr_reg == `BPS_OFS_MASK)
            mask_next = wdat_reg[3:0];
         if (waddr_reg == `BPS_OFS_STAT)
            stat_clr = wdat_reg[3:0];
      end
      irq_next = |(stat & mask_reg);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= `BPS_CTRL_RST;
         mask_reg <= `BPS_MASK_RST;
         irq      <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         mask_reg <= mask_next;
         irq      <= irq_next;
      end
   end

   // Read channel: data is captured at the address handshake
   always_comb
   begin
      rd_mapped = 1'b1;
      case (araddr)
         `BPS_OFS_CTRL: rd_word = {`BPS_PAD_CTRL, ctrl_reg};
         `BPS_OFS_STAT: rd_word = {`BPS_PAD_STAT, stat};
         `BPS_OFS_MASK: rd_word = {`BPS_PAD_STAT, mask_reg};
         default:
         begin
            rd_word   = `BPS_WORD_RST;
            rd_mapped = 1'b0;
         end
      endcase
      rvalid_next = rvalid;
      rdata_next  = rdata;
      rresp_next  = rresp;
      if (arvalid && arready)
      begin
         rvalid_next = 1'b1;
         rdata_next  = rd_word;
         rresp_next  = rd_mapped ? `BPS_RESP_OKAY : `BPS_RESP_SLVERR;
      end
      if (rvalid && rready)
         rvalid_next = 1'b0;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= `BPS_WORD_RST;
         rresp   <= `BPS_RESP_OKAY;
      end
      else
      begin
         arready <= arready_next;
         rvalid  <= rvalid_next;
         rdata   <= rdata_next;
         rresp   <= rresp_next;
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence pri_pin_held;
      (!primary_parity_error_pin_n && pri_master_active &&
       ctrl_reg[`BPS_CTRL_PRI_EN])[*3];
   endsequence
   sequence sec_pin_held;
      (!secondary_parity_error_pin_n && sec_master_active &&
       ctrl_reg[`BPS_CTRL_SEC_EN])[*3];
   endsequence

   pri_det_set_a: assert property (
      ev_pri && evt_dir == BPS_DOWN && evt_type == BPS_POSTED_WR
      |=> stat[`BPS_ST_PRI_DET])
      else $error("primary detected bit not set");
   pri_det_only_a: assert property (
      $rose(stat[`BPS_ST_PRI_DET]) |-> $past(evt_valid) &&
      $past(evt_bus) == BPS_BUS_PRI &&
      ($past(evt_dir) == BPS_UP) == ($past(evt_type) == BPS_READ))
      else $error("primary detected bit set wrongly");
   sec_det_set_a: assert property (
      ev_sec && evt_dir == BPS_UP && evt_type == BPS_DELAYED_WR
      |=> stat[`BPS_ST_SEC_DET])
      else $error("secondary detected bit not set");
   sec_det_only_a: assert property (
      $rose(stat[`BPS_ST_SEC_DET]) |-> $past(evt_valid) &&
      $past(evt_bus) == BPS_BUS_SEC &&
      ($past(evt_dir) == BPS_DOWN) == ($past(evt_type) == BPS_READ))
      else $error("secondary detected bit set wrongly");
   pri_dpd_master_a: assert property (
      $rose(stat[`BPS_ST_PRI_DPD]) |->
      $past(pri_master_active) || $past(evt_dir) == BPS_UP)
      else $error("primary parity detected without mastership");
   pri_dpd_enable_a: assert property (
      $rose(stat[`BPS_ST_PRI_DPD]) |->
      $past(ctrl_reg[`BPS_CTRL_PRI_EN]))
      else $error("primary parity detected while disabled");
   pri_pin_trigger_a: assert property (
      pri_pin_held |=> stat[`BPS_ST_PRI_DPD])
      else $error("primary pin did not set parity detected");
   pri_dpd_table_a: assert property (
      ev_pri && evt_dir == BPS_UP && ctrl_reg[`BPS_CTRL_PRI_EN]
      |=> stat[`BPS_ST_PRI_DPD])
      else $error("primary parity detected not set");
   sec_dpd_master_a: assert property (
      $rose(stat[`BPS_ST_SEC_DPD]) |->
      $past(sec_master_active) || $past(evt_dir) == BPS_DOWN)
      else $error("secondary parity detected without mastership");
   sec_dpd_enable_a: assert property (
      $rose(stat[`BPS_ST_SEC_DPD]) |->
      $past(ctrl_reg[`BPS_CTRL_SEC_EN]))
      else $error("secondary parity detected while disabled");
   sec_pin_trigger_a: assert property (
      sec_pin_held |=> stat[`BPS_ST_SEC_DPD])
      else $error("secondary pin did not set parity detected");
   sec_dpd_table_a: assert property (
      ev_sec && evt_dir == BPS_DOWN && ctrl_reg[`BPS_CTRL_SEC_EN]
      |=> stat[`BPS_ST_SEC_DPD])
      else $error("secondary parity detected not set");
   status_sticky_a: assert property (
      !wr_fire |=> (stat & $past(stat)) == $past(stat))
      else $error("status bit dropped without a clear");
endmodule

// ===== dv/bps_far_model.sv
`timescale 1ns/10ps
module bps_far_model (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Bench requests a target error report
   input  wire logic pri_go,
   input  wire logic sec_go,
   // Error pins, idle high through the bus pull-up
   output logic      primary_parity_error_pin_n,
   output logic      secondary_parity_error_pin_n
);
   logic [2:0] pri_cnt_reg;
   logic [2:0] sec_cnt_reg;

   // Pin held four clocks so the two-flop synchroniser cannot miss it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pri_cnt_reg <= 3'h0;
         sec_cnt_reg <= 3'h0;
      end
      else
      begin
         pri_cnt_reg <= pri_go ? 3'h4 : pri_cnt_reg - {2'h0, |pri_cnt_reg};
         sec_cnt_reg <= sec_go ? 3'h4 : sec_cnt_reg - {2'h0, |sec_cnt_reg};
      end
   end

   assign primary_parity_error_pin_n   = (pri_cnt_reg == 3'h0);
   assign secondary_parity_error_pin_n = (sec_cnt_reg == 3'h0);
endmodule

// ===== dv/bridge_parity_status_logic_test.sv
`timescale 1ns/10ps
`include "bps_regs.svh"
module bridge_parity_status_logic_test;
   import bps_pkg::*;
   localparam int MAX_CYC = 4000;
   logic        aclk, aresetn, irq;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd_val;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   logic [3:0]  exp_v;
   logic        evt_valid, pri_m, sec_m, pri_go, sec_go, pri_pin_n, sec_pin_n;
   bps_xact_e   evt_type;
   bps_dir_e    evt_dir;
   bps_bus_e    evt_bus;
   int          err_total = 0;
   int          checked = 0;
   int          cyc = 0;

   bps_parity_status dut (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .evt_valid(evt_valid), .evt_type(evt_type), .evt_dir(evt_dir),
      .evt_bus(evt_bus), .pri_master_active(pri_m),
      .sec_master_active(sec_m), .primary_parity_error_pin_n(pri_pin_n),
      .secondary_parity_error_pin_n(sec_pin_n), .irq(irq));

   bps_far_model far (.aclk(aclk), .aresetn(aresetn), .pri_go(pri_go),
      .sec_go(sec_go), .primary_parity_error_pin_n(pri_pin_n),
      .secondary_parity_error_pin_n(sec_pin_n));

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hung handshake ends up here rather than spinning forever
   always @(posedge aclk)
   begin
      cyc = cyc + 1;
      if (cyc == MAX_CYC)
      begin
         err_total = err_total + 1;
         tally_and_finish;
      end
   end

   task automatic cmp_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            rsp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            rd_val = rdata;
            rsp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input string nm);
      rd(a);
      cmp_word(nm, e, rd_val);
   endtask

   // Clear every status bit, then set both response enables as asked
   task automatic prep(input logic [1:0] c);
      wr(`BPS_OFS_STAT, 32'h0000_000F, 4'hF);
      wr(`BPS_OFS_CTRL, {`BPS_PAD_CTRL, c}, 4'hF);
   endtask

   task automatic ev(input int t, input int d, input int b);
      @(posedge aclk);
      evt_valid <= 1'b1;
      evt_type <= bps_xact_e'(t[1:0]);
      evt_dir <= bps_dir_e'(d[0]);
      evt_bus <= bps_bus_e'(b[0]);
      @(posedge aclk);
      evt_valid <= 1'b0;
   endtask

   function automatic logic [3:0] exp_st(input int t, input int d,
                                         input int b, input logic [1:0] en);
      logic wr_t;
      wr_t = (t != 0);
      exp_st[0] = (b == 0) && ((d == 1) != wr_t);
      exp_st[1] = (b == 1) && ((d == 0) != wr_t);
      exp_st[2] = (b == 0) && (d == 1) && en[0];
      exp_st[3] = (b == 1) && (d == 0) && en[1];
   endfunction

   initial
   begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {evt_valid, pri_m, sec_m, pri_go, sec_go} = '0;
      evt_type = BPS_READ;
      evt_dir = BPS_DOWN;
      evt_bus = BPS_BUS_PRI;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(`BPS_OFS_CTRL, `BPS_WORD_RST, "ctrl_rst");
      rd_chk(`BPS_OFS_STAT, `BPS_WORD_RST, "stat_rst");
      rd_chk(`BPS_OFS_MASK, `BPS_WORD_RST, "mask_rst");
      cmp_bit("irq_rst", 1'b0, irq);
      rd_chk(8'h0C, `BPS_WORD_RST, "unmapped_data");
      cmp_word("unmapped_resp", {30'h0000_0000, `BPS_RESP_SLVERR},
               {30'h0000_0000, rsp});
      // Every type, direction, bus and enable pair
      for (int en = 0; en < 4; en++)
         for (int t = 0; t < 3; t++)
            for (int d = 0; d < 2; d++)
               for (int b = 0; b < 2; b++)
               begin
                  prep(en[1:0]);
                  ev(t, d, b);
                  rd(`BPS_OFS_STAT);
                  exp_v = exp_st(t, d, b, en[1:0]);
                  cmp_word("status", {`BPS_PAD_STAT, exp_v}, rd_val);
                  cmp_bit("pdet", exp_v[0], rd_val[0]);
                  cmp_bit("sdet", exp_v[1], rd_val[1]);
                  cmp_bit("pdpd", exp_v[2], rd_val[2]);
                  cmp_bit("sdpd", exp_v[3], rd_val[3]);
               end
      // Reports on consecutive cycles, one per bus
      prep(2'h3);
      @(posedge aclk);
      evt_valid <= 1'b1;
      evt_type <= BPS_READ;
      evt_dir <= BPS_UP;
      evt_bus <= BPS_BUS_PRI;
      @(posedge aclk);
      evt_dir <= BPS_DOWN;
      evt_bus <= BPS_BUS_SEC;
      @(posedge aclk);
      evt_valid <= 1'b0;
      rd_chk(`BPS_OFS_STAT, 32'h0000_000F, "b2b");
      // Sticky bits, partial clears and the interrupt
      prep(2'h3);
      wr(`BPS_OFS_MASK, 32'h0000_0004, 4'hF);
      ev(0, 1, 0);
      repeat (3) @(posedge aclk);
      cmp_bit("irq_set", 1'b1, irq);
      wr(`BPS_OFS_STAT, 32'h0000_0000, 4'hF);
      wr(`BPS_OFS_STAT, 32'h0000_000F, 4'h0);
      rd_chk(`BPS_OFS_STAT, 32'h0000_0005, "stat_kept");
      wr(`BPS_OFS_MASK, 32'h0000_0001, 4'hF);
      wr(`BPS_OFS_STAT, 32'h0000_0001, 4'hF);
      repeat (3) @(posedge aclk);
      cmp_bit("irq_clear", 1'b0, irq);
      rd_chk(`BPS_OFS_STAT, 32'h0000_0004, "stat_w1c");
      rd_chk(`BPS_OFS_MASK, 32'h0000_0001, "mask_rb");
      // Target error pins: set only when mastering with enable on
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < 3; k++)
         begin
            prep((k == 2) ? 2'h0 : 2'h3);
            @(posedge aclk);
            pri_m <= (s == 0) && (k != 1);
            sec_m <= (s == 1) && (k != 1);
            pri_go <= (s == 0);
            sec_go <= (s == 1);
            @(posedge aclk);
            pri_go <= 1'b0;
            sec_go <= 1'b0;
            repeat (8) @(posedge aclk);
            pri_m <= 1'b0;
            sec_m <= 1'b0;
            rd_chk(`BPS_OFS_STAT, (k != 0) ? 32'h0000_0000 :
                   ((s == 0) ? 32'h0000_0004 : 32'h0000_0008),
                   "pin_status");
         end
      // A reset in mid-run must drop set status bits and the enables
      prep(2'h3);
      ev(0, 1, 0);
      repeat (2) @(posedge aclk);
      cmp_bit("irq_pre_rst", 1'b1, irq);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      cmp_bit("irq_mid_rst", 1'b0, irq);
      rd_chk(`BPS_OFS_STAT, `BPS_WORD_RST, "stat_mid_rst");
      rd_chk(`BPS_OFS_CTRL, `BPS_WORD_RST, "ctrl_mid_rst");
      rd_chk(`BPS_OFS_MASK, `BPS_WORD_RST, "mask_mid_rst");
      tally_and_finish;
   end
endmodule
